// File: design/icp_pkg.sv
// Constants and types shared by the isolated CAN transceiver control logic.
// Function
// (RL1) Low transmit input drives bus dominant.
// (RL2) Idle driver leaves bus biased recessive.
// (RL3) Host transmits on input, reads receive output.
// (RL4) Transmit falling edge starts dominant timer.
// (RL5) Timer expiry disables driver, flags timeout.
// (RL6) Recessive transmit input clears timeout fault.
// (RL7) During timeout: bus recessive, receive follows.
// (RL8) Controller sends at most eleven dominant bits.
// (RL9) Over-temperature blocks transmit, receive keeps working.
// (RL10) Thermal fault leaves only on release indication.
// (RL11) Undriven transmit input reads as recessive.
// (RL12) Bus supply loss: high impedance, receive high.
// (RL13) Supplies valid: resume after re-enable delay.
// (RL14) Timeout is cycle count, cleared on reset.
// (RL15) Synchronise transmit input; report faults on outputs.
package icp_pkg;

    localparam int CLK_MHZ = 200;
    localparam int DTO_MIN_US = 1200;
    localparam int DTO_MAX_US = 3800;
    localparam int DTO_NOM_US = 2500;
    localparam int UV_REENABLE_US = 300;
    localparam int CNT_W = 20;
    localparam int EVT_DEPTH = 2;

    // Nominal timeout sits inside the min/max window; the re-enable delay is a longest time.
    localparam logic [CNT_W-1:0] DTO_CYCLES = CNT_W'(DTO_NOM_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DTO_MIN_CYCLES = CNT_W'(DTO_MIN_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DTO_MAX_CYCLES = CNT_W'(DTO_MAX_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] UV_CYCLES = CNT_W'(UV_REENABLE_US * CLK_MHZ);

    localparam logic TXD_RESET = 1'h1;
    localparam logic RXD_RECESSIVE = 1'h1;

    typedef enum logic [1:0] {
        ICP_NORMAL = 2'h2,
        ICP_LOCKED = 2'h1,
        ICP_WAKE = 2'h3
    } icp_mode_type;

    typedef struct packed {
        logic uv;
        logic thermal_shutdown;
        logic dominant_timeout;
    } icp_fault_type;

    typedef struct packed {
        logic txd;
        logic bus_rx;
        logic overtemp;
        logic temp_release;
        logic bus_ok;
        logic logic_ok;
    } icp_pin_type;

    localparam icp_fault_type FAULT_NONE = 3'h0;
    localparam icp_pin_type PIN_RESET = 6'h30;

endpackage : icp_pkg

// File: design/icp_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none
module icp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_d = d_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule : icp_sync
`default_nettype wire

// File: design/icp_buf.sv
// Small valid/ready buffer that holds fault event words.
`timescale 1ns/10ps
`default_nettype none
module icp_buf #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] wr_d;
    logic [PW-1:0] rd_q;
    logic [PW-1:0] rd_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
        end
        cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    property p_buf_bound;
        @(posedge clk_i) disable iff (rst_i) cnt_q <= CW'(DEPTH);
    endproperty
    a_buf_bound: assert property (p_buf_bound) else $error("Event buffer count overflow.");
endmodule : icp_buf
`default_nettype wire

// File: design/icp_ctrl.sv
// Fault and driver control of the isolated CAN transceiver.
`timescale 1ns/10ps
`default_nettype none
module icp_ctrl
    import icp_pkg::*;
#(
    parameter logic [CNT_W-1:0] DTO_LIMIT = DTO_CYCLES,
    parameter logic [CNT_W-1:0] UV_LIMIT = UV_CYCLES
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic TXD_I,
    input wire logic TXD_DRIVEN_I,
    input wire logic BUS_RX_I,
    input wire logic OVERTEMP_I,
    input wire logic TEMP_RELEASE_I,
    input wire logic BUS_SUPPLY_OK_I,
    input wire logic LOGIC_SUPPLY_OK_I,
    output logic RXD_O,
    output logic BUS_DOM_O,
    output logic BUS_BIAS_O,
    output logic DTO_FAULT_O,
    output logic TSD_FAULT_O,
    output logic UV_FAULT_O,
    output logic EVT_VALID_O,
    output icp_fault_type EVT_DATA_O,
    input wire logic EVT_READY_I
);
    icp_pin_type pin_raw;
    icp_pin_type pin_s;
    logic supply_ok;
    logic fall;

    logic txd_prev_q;
    logic txd_prev_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic dto_q;
    logic dto_d;
    logic tsd_q;
    logic tsd_d;
    icp_mode_type mode_q;
    icp_mode_type mode_d;
    logic [CNT_W-1:0] wait_q;
    logic [CNT_W-1:0] wait_d;
    logic rxd_q;
    logic rxd_d;
    logic dom_q;
    logic dom_d;
    logic bias_q;
    logic bias_d;
    icp_fault_type pend_q;
    icp_fault_type pend_d;
    icp_fault_type new_evt;
    logic push;
    logic buf_ready;

    // (RL11) Undriven input is recessive.
    // Gating two pins before the synchroniser can glitch, but only for one sample.
    always_comb begin
        pin_raw.txd = TXD_I | ~TXD_DRIVEN_I;
        pin_raw.bus_rx = BUS_RX_I;
        pin_raw.overtemp = OVERTEMP_I;
        pin_raw.temp_release = TEMP_RELEASE_I;
        pin_raw.bus_ok = BUS_SUPPLY_OK_I;
        pin_raw.logic_ok = LOGIC_SUPPLY_OK_I;
    end

    // (RL15) Pins synchronised first.
    icp_sync #(
        .WIDTH($bits(icp_pin_type)),
        .RESET_VALUE(PIN_RESET)
    ) u_icp_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    assign supply_ok = pin_s.bus_ok & pin_s.logic_ok;
    assign fall = txd_prev_q & ~pin_s.txd;

    // Dominant timeout group.
    always_comb begin
        txd_prev_d = pin_s.txd;
        cnt_d = cnt_q;
        dto_d = dto_q;
        if (pin_s.txd) begin
            // (RL6) Recessive clears timeout.
            cnt_d = '0;
            dto_d = 1'b0;
        end else if (fall) begin
            // (RL4) Falling edge starts timer.
            cnt_d = CNT_W'(1);
        end else if (!dto_q && cnt_q != '0) begin
            // (RL5) Expiry sets timeout fault.
            if (cnt_q >= DTO_LIMIT) begin
                dto_d = 1'b1;
            end else begin
                cnt_d = CNT_W'(cnt_q + 1'b1);
            end
        end
    end

    // (RL14) Counter cleared on reset.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            txd_prev_q <= TXD_RESET;
            cnt_q <= '0;
            dto_q <= 1'b0;
        end else begin
            txd_prev_q <= txd_prev_d;
            cnt_q <= cnt_d;
            dto_q <= dto_d;
        end
    end

    // (RL10) Release ends thermal fault.
    // Over-temperature wins when both indications are high at once.
    always_comb begin
        tsd_d = tsd_q;
        if (pin_s.overtemp) begin
            tsd_d = 1'b1;
        end else if (pin_s.temp_release) begin
            tsd_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            tsd_q <= 1'b0;
        end else begin
            tsd_q <= tsd_d;
        end
    end

    // Supply state group; the device powers up locked until both supplies are valid.
    always_comb begin
        mode_d = mode_q;
        wait_d = wait_q;
        case (mode_q)
            ICP_NORMAL: begin
                if (!supply_ok) begin
                    mode_d = ICP_LOCKED;
                end
            end
            ICP_LOCKED: begin
                if (supply_ok) begin
                    mode_d = ICP_WAKE;
                    wait_d = '0;
                end
            end
            ICP_WAKE: begin
                // (RL13) Resume after re-enable delay.
                if (!supply_ok) begin
                    mode_d = ICP_LOCKED;
                end else if (wait_q >= CNT_W'(UV_LIMIT - 1'b1)) begin
                    mode_d = ICP_NORMAL;
                end else begin
                    wait_d = CNT_W'(wait_q + 1'b1);
                end
            end
            default: begin
                mode_d = ICP_LOCKED;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            mode_q <= ICP_LOCKED;
            wait_q <= '0;
        end else begin
            mode_q <= mode_d;
            wait_q <= wait_d;
        end
    end

    // Bus and receive outputs group.
    always_comb begin
        // (RL1) Dominant only when enabled.
        // (RL9) Thermal fault blocks transmit.
        dom_d = (mode_q == ICP_NORMAL) & supply_ok & ~dto_q & ~tsd_q & ~pin_s.txd;
        // (RL12) Bus supply loss floats.
        bias_d = pin_s.bus_ok;
        // (RL3) Receive mirrors the bus.
        // (RL7) Receive follows during timeout.
        rxd_d = RXD_RECESSIVE;
        if (mode_q == ICP_NORMAL && supply_ok) begin
            rxd_d = pin_s.bus_rx;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            dom_q <= 1'b0;
            bias_q <= 1'b0;
            rxd_q <= RXD_RECESSIVE;
        end else begin
            dom_q <= dom_d;
            bias_q <= bias_d;
            rxd_q <= rxd_d;
        end
    end

    // (RL2) Idle driver stays recessive.
    assign BUS_DOM_O = dom_q;
    assign BUS_BIAS_O = bias_q;
    assign RXD_O = rxd_q;

    // (RL15) Faults on status outputs.
    assign DTO_FAULT_O = dto_q;
    assign TSD_FAULT_O = tsd_q;
    assign UV_FAULT_O = (mode_q != ICP_NORMAL);

    // Event group: a stalled buffer holds events here, merged, so none is lost.
    always_comb begin
        new_evt.dominant_timeout = dto_d & ~dto_q;
        new_evt.thermal_shutdown = tsd_d & ~tsd_q;
        new_evt.uv = (mode_d != ICP_NORMAL) & (mode_q == ICP_NORMAL);
        push = (pend_q != FAULT_NONE) & buf_ready;
        pend_d = icp_fault_type'((push ? FAULT_NONE : pend_q) | new_evt);
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            pend_q <= FAULT_NONE;
        end else begin
            pend_q <= pend_d;
        end
    end

    icp_buf #(
        .WIDTH($bits(icp_fault_type)),
        .DEPTH(EVT_DEPTH)
    ) u_icp_buf (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .in_valid_i(pend_q != FAULT_NONE),
        .in_ready_o(buf_ready),
        .in_data_i(pend_q),
        .out_valid_o(EVT_VALID_O),
        .out_ready_i(EVT_READY_I),
        .out_data_o(EVT_DATA_O)
    );

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    sequence s_tx_enabled;
        (mode_q == ICP_NORMAL) && supply_ok && !dto_q && !tsd_q;
    endsequence

    sequence s_wake_done;
        (mode_q == ICP_WAKE) && supply_ok && (wait_q == CNT_W'(UV_LIMIT - 1'b1));
    endsequence

    property p_dom_drive;
        s_tx_enabled ##0 !pin_s.txd |=> BUS_DOM_O;
    endproperty
    a_dom_drive: assert property (p_dom_drive) else $error("Dominant not driven."); // (RL1)

    property p_idle_recessive;
        (pin_s.txd || dto_q || tsd_q || mode_q != ICP_NORMAL) |=> !BUS_DOM_O;
    endproperty
    a_idle_recessive: assert property (p_idle_recessive) else $error("Driver not idle."); // (RL2)

    property p_rx_mirror;
        (mode_q == ICP_NORMAL && supply_ok) |=> (RXD_O == $past(pin_s.bus_rx));
    endproperty
    a_rx_mirror: assert property (p_rx_mirror) else $error("Receive not mirroring bus."); // (RL3)

    property p_timer_start;
        fall |=> (cnt_q == CNT_W'(1)) ##1 (pin_s.txd || cnt_q == CNT_W'(2) || dto_q);
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("Timer did not start."); // (RL4)

    property p_dto_set;
        $rose(dto_q) |-> ($past(cnt_q) == DTO_LIMIT) && !$past(pin_s.txd) ##1 !BUS_DOM_O;
    endproperty
    a_dto_set: assert property (p_dto_set) else $error("Timeout set at wrong count."); // (RL5)

    property p_dto_clear;
        (dto_q && pin_s.txd) |=> !dto_q && (cnt_q == '0);
    endproperty
    a_dto_clear: assert property (p_dto_clear) else $error("Timeout not cleared."); // (RL6)

    property p_dto_hold;
        (dto_q && mode_q == ICP_NORMAL && supply_ok) |=>
            !BUS_DOM_O && (RXD_O == $past(pin_s.bus_rx));
    endproperty
    a_dto_hold: assert property (p_dto_hold) else $error("Timeout state wrong."); // (RL7)

    property p_tsd_block;
        tsd_q |=> !BUS_DOM_O ##1 (tsd_q || !BUS_DOM_O || $past(pin_s.temp_release));
    endproperty
    a_tsd_block: assert property (p_tsd_block) else $error("Thermal fault drove bus."); // (RL9)

    property p_tsd_release;
        (tsd_q && !pin_s.temp_release) |=> tsd_q;
    endproperty
    a_tsd_release: assert property (p_tsd_release) else $error("Thermal left early."); // (RL10)

    property p_uv_float;
        !pin_s.bus_ok |=> RXD_O && !BUS_BIAS_O && !BUS_DOM_O;
    endproperty
    a_uv_float: assert property (p_uv_float) else $error("Undervoltage state wrong."); // (RL12)

    property p_wake;
        s_wake_done |=> (mode_q == ICP_NORMAL) && !UV_FAULT_O;
    endproperty
    a_wake: assert property (p_wake) else $error("No resume after delay."); // (RL13)
endmodule : icp_ctrl
`default_nettype wire

// File: verification/icp_host_model.sv
// Behavioural host controller that drives the transmit pin.
`timescale 1ns/10ps
`default_nettype none
module icp_host_model (
    input wire logic clk_i,
    input wire logic rxd_i,
    output logic txd_o,
    output logic txd_driven_o,
    output logic rxd_seen_o
);
    initial begin
        txd_o = 1'h1;
        txd_driven_o = 1'h1;
        rxd_seen_o = 1'h1;
    end
    always @(posedge clk_i) rxd_seen_o <= rxd_i;
    // drive or float.
    // A floating pin shows low here on purpose, since the weak pull-up may lose.
    task automatic put(input logic lvl, input logic drv);
        @(posedge clk_i);
        txd_o <= drv ? lvl : 1'h0;
        txd_driven_o <= drv;
    endtask : put
    task automatic frame(input logic [15:0] bits, input int bit_cyc);
        for (int i = 15; i >= 0; i--) begin
            put(bits[i], 1'h1);
            repeat (bit_cyc - 1) @(posedge clk_i);
        end
    endtask : frame
endmodule : icp_host_model
`default_nettype wire

// File: verification/test_icp_ctrl.sv
// Self-checking testbench of the transceiver fault and driver control.
`timescale 1ns/10ps
`default_nettype none
module test_icp_ctrl;
    import icp_pkg::*;
    localparam int DTO_LIM = 40;
    localparam int UV_LIM = 20;
    logic clk, rst, txd, txd_drv, bus_rx, overtemp, temp_rel, bus_ok, logic_ok;
    logic rxd, bus_dom, bus_bias, dto_f, tsd_f, uv_f, evt_valid, evt_ready, other;
    icp_fault_type evt_data;
    int err_total = 0;
    int num_checks = 0;
    int dto_hits = 0;
    int rx_lows = 0;
    int n;
    int h0;
    int r0;
    // The bus is dominant while any node drives it; otherwise bias or open reads recessive.
    assign bus_rx = !(bus_dom | other);
    icp_ctrl #(.DTO_LIMIT(CNT_W'(DTO_LIM)), .UV_LIMIT(CNT_W'(UV_LIM))) u_icp_ctrl (
        .CLK_SYS_I(clk), .RST_I(rst), .TXD_I(txd), .TXD_DRIVEN_I(txd_drv),
        .BUS_RX_I(bus_rx), .OVERTEMP_I(overtemp), .TEMP_RELEASE_I(temp_rel),
        .BUS_SUPPLY_OK_I(bus_ok), .LOGIC_SUPPLY_OK_I(logic_ok), .RXD_O(rxd),
        .BUS_DOM_O(bus_dom), .BUS_BIAS_O(bus_bias), .DTO_FAULT_O(dto_f),
        .TSD_FAULT_O(tsd_f), .UV_FAULT_O(uv_f), .EVT_VALID_O(evt_valid),
        .EVT_DATA_O(evt_data), .EVT_READY_I(evt_ready));
    icp_host_model u_icp_host_model (.clk_i(clk), .rxd_i(rxd), .txd_o(txd),
        .txd_driven_o(txd_drv), .rxd_seen_o());
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (dto_f === 1'h1) dto_hits++;
        if (rxd === 1'h0) rx_lows++;
    end
    task automatic chk(input string name, input logic [2:0] seen, input logic [2:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic end_of_test;
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic t_reset;
        settle(3);
        chk("reset state", {rxd, bus_dom, bus_bias}, 3'h5);
        chk("reset faults", {uv_f, tsd_f, dto_f}, 3'h4);
        n = 0;
        while (uv_f !== 1'h0 && n < 60) begin settle(0); n++; end
        chk("normal reached", {uv_f, bus_bias, rxd}, 3'h3);
    endtask : t_reset
    task automatic t_tx;
        u_icp_host_model.put(1'h0, 1'h1);
        settle(3);
        chk("dominant drive", bus_dom, 1'h1);
        settle(3);
        chk("receive dominant", rxd, 1'h0);
        u_icp_host_model.put(1'h1, 1'h1);
        settle(6);
        chk("recessive idle", {bus_dom, rxd}, 3'h1);
        h0 = dto_hits;
        r0 = rx_lows;
        u_icp_host_model.frame(16'hC007, 3);
        settle(6);
        chk("no timeout in frame", dto_hits == h0, 1'h1);
        chk("frame echoed", rx_lows > r0, 1'h1);
        u_icp_host_model.put(1'h0, 1'h1);
        repeat (30) @(posedge clk);
        u_icp_host_model.put(1'h1, 1'h1);
        repeat (3) @(posedge clk);
        u_icp_host_model.put(1'h0, 1'h1);
        repeat (30) @(posedge clk);
        u_icp_host_model.put(1'h1, 1'h1);
        settle(6);
        chk("timer restarts", dto_hits == h0, 1'h1);
    endtask : t_tx
    task automatic t_dto;
        u_icp_host_model.put(1'h0, 1'h1);
        settle(3);
        n = 0;
        while (dto_f !== 1'h1 && n < 80) begin settle(0); n++; end
        chk("timeout delay", n >= DTO_LIM - 4 && n <= DTO_LIM + 4, 1'h1);
        settle(1);
        chk("driver off", {bus_dom, bus_bias, dto_f}, 3'h3);
        @(posedge clk) other <= 1'h1;
        settle(3);
        chk("receive follows", rxd, 1'h0);
        @(posedge clk) other <= 1'h0;
        u_icp_host_model.put(1'h1, 1'h1);
        settle(3);
        chk("timeout cleared", dto_f, 1'h0);
    endtask : t_dto
    task automatic t_tsd;
        @(posedge clk);
        overtemp <= 1'h1;
        other <= 1'h1;
        u_icp_host_model.put(1'h0, 1'h1);
        settle(4);
        chk("shutdown", {tsd_f, bus_dom, rxd}, 3'h4);
        u_icp_host_model.put(1'h1, 1'h1);
        @(posedge clk);
        overtemp <= 1'h0;
        other <= 1'h0;
        settle(6);
        chk("held without release", tsd_f, 1'h1);
        @(posedge clk) temp_rel <= 1'h1;
        settle(3);
        chk("released", tsd_f, 1'h0);
        @(posedge clk) temp_rel <= 1'h0;
    endtask : t_tsd
    task automatic t_float;
        u_icp_host_model.put(1'h0, 1'h0);
        settle(6);
        chk("floating recessive", {bus_dom, rxd}, 3'h1);
        u_icp_host_model.put(1'h1, 1'h1);
    endtask : t_float
    task automatic t_uv;
        @(posedge clk);
        bus_ok <= 1'h0;
        other <= 1'h1;
        settle(3);
        chk("bus supply lost", {bus_bias, rxd, uv_f}, 3'h3);
        @(posedge clk) bus_ok <= 1'h1;
        settle(UV_LIM);
        chk("still waking", uv_f, 1'h1);
        settle(6);
        chk("resumed", {uv_f, rxd}, 3'h0);
        @(posedge clk) logic_ok <= 1'h0;
        settle(3);
        chk("logic supply lost", {rxd, bus_bias}, 3'h3);
        @(posedge clk);
        logic_ok <= 1'h1;
        other <= 1'h0;
        settle(UV_LIM + 6);
    endtask : t_uv
    task automatic t_drain;
        logic [2:0] exp [3] = '{3'h1, 3'h2, 3'h4};
        for (int k = 0; k < 3; k++) begin
            n = 0;
            while (evt_valid !== 1'h1 && n < 10) begin settle(0); n++; end
            chk("event word", evt_data, exp[k]);
            @(posedge clk) evt_ready <= 1'h1;
            @(posedge clk) evt_ready <= 1'h0;
            settle(0);
        end
        settle(3);
        chk("events drained", evt_valid, 1'h0);
    endtask : t_drain
    initial begin
        rst = 1'h1;
        other = 1'h0;
        overtemp = 1'h0;
        temp_rel = 1'h0;
        bus_ok = 1'h1;
        logic_ok = 1'h1;
        evt_ready = 1'h0;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_tx();
        // Events pile up unread here so the buffer fills and stalls.
        t_dto();
        t_tsd();
        t_float();
        t_uv();
        t_drain();
        end_of_test();
    end
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end
endmodule : test_icp_ctrl
`default_nettype wire
